// File: rtl/logic_cell.sv
// Purpose: configurable logic cell with three lookup generators and two storage elements
// Assumes: cell pins come from another domain and are synchronised here
// Notes:   configuration lives in apb registers and is meant to stay static
//
// Function
// - two independent four-input lookup generators each make any function of their inputs.
// - a three-input generator takes two inputs selectable between a first-stage result and a pin.
// - output x carries f or h, output y carries g or h, as configured.
// - only two generator results leave the cell without a storage element, a third must go through storage.
// - the cell offers thirteen interconnect inputs and four outputs.
// - combining generators yields any five-input function or two four-input plus one three-input.
// - two d-type storage elements share one clock and one enable and can be used standalone.
// - the direct input can feed either element, the other may take a pin through the h generator.
// - each element may capture on the rising or falling cell clock edge by its own inversion.
// - the shared enable is active high, not invertible, and low enable holds the value.
// - each element may be set to ignore the shared enable and stay enabled.
// - in flip-flop mode the element loads data on the active edge and holds otherwise.
// - in latch mode the element follows data while the clock is low and holds while high.
// - power-up, global set/reset or local set/reset force the configured value over all else.
// - one bit per element picks set or reset for all three set/reset sources.
// - local set/reset is asynchronous, active high and not invertible in the cell.
`timescale 1ns/1ps
`default_nettype none
module logic_cell
  import logic_cell_pkg::*;
#(
  parameter int unsigned NUM_ELEM = 2
)
(
  input  wire logic              mclk_i,
  input  wire logic              rst_b_i,
  input  wire logic              en_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic                   pready_o,
  output logic                   pslverr_o,
  output logic [31:0]            prdata_o,
  // interconnect side
  input  wire logic [3:0]        f_in_i,
  input  wire logic [3:0]        g_in_i,
  input  wire logic              combine_in_zero_i,
  input  wire logic              combine_in_one_i,
  input  wire logic              combine_in_two_i,
  input  wire logic              cell_clk_enable_i,
  input  wire logic              cell_clk_i,
  input  wire logic              global_set_reset_i,
  output logic                   comb_x_o,
  output logic                   comb_y_o,
  output logic                   reg_out_a_o,
  output logic                   reg_out_b_o
);

  // configuration and status state
  logic [LUT4_W-1:0]  lut_f;
  logic [LUT4_W-1:0]  lut_g;
  logic [LUT3_W-1:0]  lut_h;
  logic [ROUTE_W-1:0] route;
  logic [STORE_W-1:0] store;
  logic [PIN_W-1:0]   pin_meta;
  logic [PIN_W-1:0]   pin_sync;
  logic               clk_prev;
  logic               comb_x;
  logic               comb_y;
  logic               pready;
  logic               pslverr;
  logic [31:0]        prdata;

  // pin vector: thirteen cell inputs plus the global set/reset
  wire [PIN_W-1:0] pin_raw = {global_set_reset_i, cell_clk_i, cell_clk_enable_i,
                              combine_in_two_i, combine_in_one_i, combine_in_zero_i,
                              g_in_i, f_in_i};

  // two-stage synchroniser; only pin_sync is read by logic
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
      clk_prev <= 1'b0;
    end
    else if (en_i)
    begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      clk_prev <= pin_sync[PIN_CLK];
    end
  end

  // synchronised pin views
  wire [3:0] f_idx  = pin_sync[PIN_F_LO +: 4];
  wire [3:0] g_idx  = pin_sync[PIN_G_LO +: 4];
  wire       in0    = pin_sync[PIN_IN0];
  wire       in1    = pin_sync[PIN_IN1];
  wire       in2    = pin_sync[PIN_IN2];
  wire       ce_s   = pin_sync[PIN_CE];
  wire       clk_s  = pin_sync[PIN_CLK];
  wire       global_sr_s = pin_sync[PIN_GLOB_SR];

  // first-stage generators are plain table lookups, so delay is function-independent
  wire f_val = lut_f[f_idx];
  wire g_val = lut_g[g_idx];

  // h inputs: outer two may come from f/g, middle one is always a pin
  wire h_in0 = route[RT_HIN0_FROM_G] ? g_val : in0;
  wire h_in2 = route[RT_HIN2_FROM_F] ? f_val : in2;
  // with both selects set, h of f, g and in1 covers any five-input function
  wire [2:0] h_idx = {h_in2, in1, h_in0};
  wire h_val = lut_h[h_idx];

  // combinational outputs; registered only to keep ports flop-driven
  wire next_comb_x = route[RT_X_FROM_H] ? h_val : f_val;
  wire next_comb_y = route[RT_Y_FROM_H] ? h_val : g_val;

  // only x and y carry raw generator results; a third result needs an element
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      comb_x <= 1'b0;
      comb_y <= 1'b0;
    end
    else if (en_i)
    begin
      comb_x <= next_comb_x;
      comb_y <= next_comb_y;
    end
  end

  // storage elements: element 0 may take f, element 1 may take g
  wire [NUM_ELEM-1:0] gen_val = {g_val, f_val};
  wire [NUM_ELEM-1:0] elem_q;

  storage_if st_if [NUM_ELEM] ();

  for (genvar i = 0; i < NUM_ELEM; i++)
  begin : g_elem
    localparam int unsigned BASE = i * ST_ELEM_W;
    wire [1:0] dsrc = store[BASE + ST_DSRC_LO +: 2];
    // direct input serves both elements; h carries in1 to either
    wire d_sel = (dsrc == DSRC_GEN) ? gen_val[i] :
                 (dsrc == DSRC_H)   ? h_val      : in2;

    // shared clock and enable, per-element polarity and options
    assign st_if[i].d         = d_sel;
    assign st_if[i].clk_lvl   = clk_s;
    assign st_if[i].clk_prev  = clk_prev;
    assign st_if[i].ce        = ce_s;
    assign st_if[i].sr        = in0;
    assign st_if[i].global_sr = global_sr_s;
    assign st_if[i].run       = en_i;
    assign st_if[i].clk_inv   = store[BASE + ST_CLK_INV];
    assign st_if[i].latch     = store[BASE + ST_LATCH];
    assign st_if[i].ce_always = store[BASE + ST_CE_ALWAYS];
    assign st_if[i].sr_val    = store[BASE + ST_SR_VAL];
    assign st_if[i].sr_en     = store[BASE + ST_SR_EN];
    assign elem_q[i]          = st_if[i].q;

    storage_element u_elem (
      .mclk_i  (mclk_i),
      .rst_b_i (rst_b_i),
      .port    (st_if[i])
    );
  end

  // apb decode
  wire setup_ph = psel_i & ~penable_i;
  wire access   = psel_i & penable_i & pready;
  wire wr_go    = access & pwrite_i;
  wire hit_f    = (paddr_i == OFS_LUT_F);
  wire hit_g    = (paddr_i == OFS_LUT_G);
  wire hit_h    = (paddr_i == OFS_LUT_H);
  wire hit_rt   = (paddr_i == OFS_ROUTE);
  wire hit_st   = (paddr_i == OFS_STORE);
  wire hit_sts  = (paddr_i == OFS_STATUS);
  wire mapped   = hit_f | hit_g | hit_h | hit_rt | hit_st | hit_sts;

  // status shows the live outputs of the cell
  wire [STATUS_W-1:0] status = {elem_q[1], elem_q[0], comb_y, comb_x};

  // read mux; unused upper bits read as zero
  wire [31:0] rd_mux =
    hit_f   ? {{(32-LUT4_W){1'b0}}, lut_f}    :
    hit_g   ? {{(32-LUT4_W){1'b0}}, lut_g}    :
    hit_h   ? {{(32-LUT3_W){1'b0}}, lut_h}    :
    hit_rt  ? {{(32-ROUTE_W){1'b0}}, route}   :
    hit_st  ? {{(32-STORE_W){1'b0}}, store}   :
    hit_sts ? {{(32-STATUS_W){1'b0}}, status} : 32'h0000_0000;

  // bus handshake: ready rises in the first access cycle, no wait states
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (en_i)
    begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~mapped;
      if (setup_ph & ~pwrite_i)
        prdata <= rd_mux;
    end
  end

  // configuration registers; status is read-only and ignores writes
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lut_f <= LUT4_RST;
      lut_g <= LUT4_RST;
      lut_h <= LUT3_RST;
      route <= ROUTE_RST;
      store <= STORE_RST;
    end
    else if (en_i && wr_go)
    begin
      if (hit_f)
        lut_f <= pwdata_i[LUT4_W-1:0];
      if (hit_g)
        lut_g <= pwdata_i[LUT4_W-1:0];
      if (hit_h)
        lut_h <= pwdata_i[LUT3_W-1:0];
      if (hit_rt)
        route <= pwdata_i[ROUTE_W-1:0];
      if (hit_st)
        store <= pwdata_i[STORE_W-1:0];
    end
  end

  // ports straight from flops
  assign pready_o    = pready;
  assign pslverr_o   = pslverr;
  assign prdata_o    = prdata;
  assign comb_x_o    = comb_x;
  assign comb_y_o    = comb_y;
  assign reg_out_a_o = elem_q[0];
  assign reg_out_b_o = elem_q[1];

  comb_x_f_a : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    en_i && !route[RT_X_FROM_H] |=> comb_x == $past(lut_f[f_idx]))
    else $error("x output does not carry f");

  comb_y_h_a : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    en_i && route[RT_Y_FROM_H] |=> comb_y == $past(lut_h[h_idx]))
    else $error("y output does not carry h");

  five_input_a : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    en_i && route[RT_X_FROM_H] && route[RT_HIN0_FROM_G] && route[RT_HIN2_FROM_F]
    |=> comb_x == $past(lut_h[{lut_f[f_idx], in1, lut_g[g_idx]}]))
    else $error("h does not combine f and g");

  lut_write_a : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    en_i && wr_go && hit_f |=> lut_f == $past(pwdata_i[LUT4_W-1:0]))
    else $error("f table write lost");

  apb_ready_a : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    en_i && setup_ph ##1 en_i |-> pready ##1 !pready)
    else $error("ready not a single access cycle");

  global_force_a : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    en_i && global_sr_s |=> elem_q[0] == $past(store[ST_SR_VAL]))
    else $error("global set/reset did not force element 0");

  bad_addr_a : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    en_i && setup_ph && !mapped |=> pslverr)
    else $error("unmapped address not flagged");

endmodule : logic_cell
`default_nettype wire

// File: rtl/logic_cell_pkg.sv
// Purpose: constants shared by the logic cell and its storage elements
// Assumes: apb byte addresses, one 32-bit word per register
// Notes:   configuration words are static once software has written them
package logic_cell_pkg;

  // apb address map
  localparam int unsigned ADDR_W     = 8;
  localparam logic [7:0]  OFS_LUT_F  = 8'h00;
  localparam logic [7:0]  OFS_LUT_G  = 8'h04;
  localparam logic [7:0]  OFS_LUT_H  = 8'h08;
  localparam logic [7:0]  OFS_ROUTE  = 8'h0c;
  localparam logic [7:0]  OFS_STORE  = 8'h10;
  localparam logic [7:0]  OFS_STATUS = 8'h14;

  // lookup table widths
  localparam int unsigned LUT4_W = 16;
  localparam int unsigned LUT3_W = 8;

  // route register fields
  localparam int unsigned ROUTE_W        = 4;
  localparam int unsigned RT_HIN0_FROM_G = 0;
  localparam int unsigned RT_HIN2_FROM_F = 1;
  localparam int unsigned RT_X_FROM_H    = 2;
  localparam int unsigned RT_Y_FROM_H    = 3;

  // store register: one byte-wide field group per element
  localparam int unsigned STORE_W      = 16;
  localparam int unsigned ST_ELEM_W    = 8;
  localparam int unsigned ST_DSRC_LO   = 0;
  localparam int unsigned ST_CLK_INV   = 2;
  localparam int unsigned ST_LATCH     = 3;
  localparam int unsigned ST_CE_ALWAYS = 4;
  localparam int unsigned ST_SR_VAL    = 5;
  localparam int unsigned ST_SR_EN     = 6;

  // status register fields
  localparam int unsigned STATUS_W = 4;
  localparam int unsigned STS_X    = 0;
  localparam int unsigned STS_Y    = 1;
  localparam int unsigned STS_QA   = 2;
  localparam int unsigned STS_QB   = 3;

  // reset values
  localparam logic [15:0]       LUT4_RST  = 16'h0000;
  localparam logic [7:0]        LUT3_RST  = 8'h00;
  localparam logic [ROUTE_W-1:0] ROUTE_RST = 4'h0;
  localparam logic [STORE_W-1:0] STORE_RST = 16'h4040;

  // synchronised pin vector layout
  localparam int unsigned PIN_W   = 14;
  localparam int unsigned PIN_F_LO = 0;
  localparam int unsigned PIN_G_LO = 4;
  localparam int unsigned PIN_IN0 = 8;
  localparam int unsigned PIN_IN1 = 9;
  localparam int unsigned PIN_IN2 = 10;
  localparam int unsigned PIN_CE  = 11;
  localparam int unsigned PIN_CLK = 12;
  localparam int unsigned PIN_GLOB_SR = 13;

  // storage element data source
  typedef enum logic [1:0] {
    DSRC_DIRECT = 2'b00,
    DSRC_GEN    = 2'b01,
    DSRC_H      = 2'b10
  } dsrc_e;

endpackage : logic_cell_pkg

// File: rtl/storage_element.sv
// Purpose: one flip-flop or latch of the logic cell
// Assumes: cell clock arrives as a synchronised level plus its previous sample
// Notes:   edges and transparency are resolved at mclk resolution
`timescale 1ns/1ps
`default_nettype none
module storage_element
  import logic_cell_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  storage_if.elem   port
);

  logic init_pending;
  logic q;

  // per-element clock inversion on the shared cell clock
  wire k_now  = port.clk_lvl ^ port.clk_inv;
  wire k_prev = port.clk_prev ^ port.clk_inv;
  wire k_rise = k_now & ~k_prev;
  wire ce_eff = port.ce_always | port.ce;
  // one polarity bit serves power-up, global and local set/reset alike
  wire force_sr = init_pending | port.global_sr | (port.sr_en & port.sr);
  wire load_ff  = ~port.latch & k_rise & ce_eff;
  wire load_lat = port.latch & ~k_now & ce_eff;

  // async reset takes a constant; the configured value lands on the first edge
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      init_pending <= 1'b1;
      q            <= 1'b0;
    end
    else if (port.run)
    begin
      init_pending <= 1'b0;
      if (force_sr)
        q <= port.sr_val;
      else if (load_ff | load_lat)
        q <= port.d;
    end
  end

  assign port.q = q;

  sr_force_a : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    port.run && port.sr_en && port.sr |=> q == $past(port.sr_val))
    else $error("set/reset did not force the element");

  ff_load_a : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    port.run && !force_sr && !port.latch && k_rise && ce_eff
    |=> q == $past(port.d))
    else $error("flip-flop missed its active edge");

  ff_hold_a : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    port.run && !force_sr && !port.latch && !k_rise |=> $stable(q))
    else $error("flip-flop changed without an edge");

  ce_hold_a : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    port.run && !force_sr && !port.ce && !port.ce_always |=> $stable(q))
    else $error("element changed with enable low");

  ce_always_a : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    port.run && !force_sr && port.latch && !k_now && port.ce_always
    |=> q == $past(port.d))
    else $error("forced enable did not take effect");

  latch_hold_a : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    port.run && !force_sr && port.latch && k_now |=> $stable(q))
    else $error("latch changed while closed");

endmodule : storage_element
`default_nettype wire

// File: rtl/storage_if.sv
// Purpose: bundle between the cell and one storage element
// Assumes: all members are on mclk_i
// Notes:   cell drives data and configuration, element returns q
`timescale 1ns/1ps
`default_nettype none
interface storage_if;
  logic d;
  logic clk_lvl;
  logic clk_prev;
  logic ce;
  logic sr;
  logic global_sr;
  logic run;
  logic clk_inv;
  logic latch;
  logic ce_always;
  logic sr_val;
  logic sr_en;
  logic q;

  modport owner (
    output d, clk_lvl, clk_prev, ce, sr, global_sr, run,
    output clk_inv, latch, ce_always, sr_val, sr_en,
    input  q
  );
  modport elem (
    input  d, clk_lvl, clk_prev, ce, sr, global_sr, run,
    input  clk_inv, latch, ce_always, sr_val, sr_en,
    output q
  );
endinterface : storage_if
`default_nettype wire

// File: verif/interconnect_model.sv
// Purpose: far-side interconnect model that drives the cell clock pin
// Assumes: the bench asks for a clock level, the model follows it
// Notes:   each clock phase lasts at least five mclk so the cell can see every edge
`timescale 1ns/1ps
`default_nettype none
module interconnect_model
(
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  input  wire logic k_req_i,
  output logic      k_o
);
  logic [2:0] phase_cnt;

  // the clock stands still unless asked; a short phase would be missed by edge detection
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      k_o       <= 1'b0;
      phase_cnt <= 3'h0;
    end
    else if ((k_req_i != k_o) && (phase_cnt >= 3'h4))
    begin
      k_o       <= k_req_i;
      phase_cnt <= 3'h0;
    end
    else if (phase_cnt != 3'h7)
    begin
      phase_cnt <= phase_cnt + 3'h1;
    end
  end
endmodule : interconnect_model
`default_nettype wire

// File: verif/logic_cell_bench.sv
// Purpose: self-checking bench for the configurable logic cell
// Assumes: en_i held high except while test_lut drops it, all pin changes land on a rising mclk edge
// Notes:   waits cover the two-flop pin synchroniser plus output flop
`timescale 1ns/1ps
`default_nettype none
module logic_cell_bench;
  import logic_cell_pkg::*;
  logic              mclk_i, rst_b_i, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic [3:0]        f_in, g_in;
  logic              hin0, hin1, hin2, ce, k_req, k, global_sr, en, x, y, qa, qb;
  int                failures, tests_run, cycles;
  localparam logic [15:0] LF = 16'h8e3b;
  localparam logic [15:0] LG = 16'h5a0f;
  localparam logic [7:0]  LH = 8'hb4;

  logic_cell u_logic_cell (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .en_i(en),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pready_o(pready), .pslverr_o(pslverr), .prdata_o(prdata),
    .f_in_i(f_in), .g_in_i(g_in), .combine_in_zero_i(hin0), .combine_in_one_i(hin1),
    .combine_in_two_i(hin2), .cell_clk_enable_i(ce), .cell_clk_i(k),
    .global_set_reset_i(global_sr), .comb_x_o(x), .comb_y_o(y),
    .reg_out_a_o(qa), .reg_out_b_o(qb));
  interconnect_model u_interconnect_model (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .k_req_i(k_req), .k_o(k));

  // free-running clock and a hang guard
  initial
  begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : wait_cyc

  // one apb transfer; holds the request until pready is seen at an edge
  // only the bench timeout ends a wait for ready
  task automatic xfer(input int wr, input logic [7:0] a, input logic [31:0] wd,
                      input logic [31:0] exp, input int exp_err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr[0];
    paddr   <= a;
    pwdata  <= wd;
    @(posedge mclk_i);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk_i);
    end while (pready !== 1'b1);
    check({31'h0, pslverr}, {31'h0, exp_err[0]});
    if (wr == 0)
      check(prdata, exp);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_i);
  endtask : xfer

  task automatic pins(input logic [3:0] f, input logic [3:0] g, input logic [2:0] h);
    f_in <= f;
    g_in <= g;
    {hin2, hin1, hin0} <= h;
    wait_cyc(6);
  endtask : pins

  // one full cell clock pulse, rising then falling
  task automatic kpulse();
    k_req <= 1'b1;
    wait_cyc(12);
    k_req <= 1'b0;
    wait_cyc(12);
  endtask : kpulse

  task automatic test_regs();
    xfer(0, OFS_LUT_F, 0, 32'(LUT4_RST), 0);
    xfer(0, OFS_LUT_H, 0, 32'(LUT3_RST), 0);
    xfer(0, OFS_ROUTE, 0, 32'(ROUTE_RST), 0);
    xfer(0, OFS_STORE, 0, 32'(STORE_RST), 0);
    xfer(1, OFS_STATUS, 32'hf, 0, 0);
    xfer(0, OFS_STATUS, 0, 32'h0, 0);
    xfer(0, 8'h18, 0, 32'h0, 1);
    xfer(1, 8'hfc, 32'h1, 0, 1);
    $display("test regs done");
  endtask : test_regs

  task automatic test_lut();
    xfer(1, OFS_LUT_F, 32'(LF), 0, 0);
    xfer(1, OFS_LUT_G, 32'(LG), 0, 0);
    for (int i = 0; i < 16; i++)
    begin
      pins(4'(i), 4'(15 - i), 3'h0);
      check({31'h0, x}, {31'h0, LF[i]});
      check({31'h0, y}, {31'h0, LG[15 - i]});
    end
    // enable low freezes synchroniser and output flops, x keeps f of the last index
    en <= 1'b0;
    pins(4'h2, 4'h0, 3'h0);
    check({31'h0, x}, {31'h0, LF[15]});
    en <= 1'b1;
    wait_cyc(6);
    check({31'h0, x}, {31'h0, LF[2]});
    $display("test lut done");
  endtask : test_lut

  task automatic test_h();
    logic [3:0] fi;
    logic [3:0] gi;
    xfer(1, OFS_LUT_H, 32'(LH), 0, 0);
    xfer(1, OFS_ROUTE, 32'h0000000c, 0, 0);
    for (int i = 0; i < 8; i++)
    begin
      pins(4'h0, 4'h0, 3'(i));
      check({31'h0, x}, {31'h0, LH[i]});
      check({31'h0, y}, {31'h0, LH[i]});
    end
    // h fed by both first-stage results, y still carries g
    xfer(1, OFS_ROUTE, 32'h00000007, 0, 0);
    for (int i = 1; i < 3; i++)
    begin
      fi = 4'(i);
      gi = 4'(4 * i - 4);
      pins(fi, gi, {1'b0, 1'(i - 1), 1'b0});
      check({31'h0, x}, {31'h0, LH[{LF[fi], 1'(i - 1), LG[gi]}]});
      check({31'h0, y}, {31'h0, LG[gi]});
    end
    xfer(1, OFS_ROUTE, 32'h0, 0, 0);
    $display("test h done");
  endtask : test_h

  task automatic test_ff();
    xfer(1, OFS_STORE, 32'h00000400, 0, 0);
    ce <= 1'b1;
    pins(4'h0, 4'h0, 3'b100);
    k_req <= 1'b1;
    wait_cyc(12);
    check({30'h0, qb, qa}, 32'h1);
    k_req <= 1'b0;
    wait_cyc(12);
    check({30'h0, qb, qa}, 32'h3);
    ce <= 1'b0;
    pins(4'h0, 4'h0, 3'b000);
    kpulse();
    check({30'h0, qb, qa}, 32'h3);
    xfer(1, OFS_STORE, 32'h00001400, 0, 0);
    kpulse();
    check({30'h0, qb, qa}, 32'h1);
    ce <= 1'b1;
    $display("test ff done");
  endtask : test_ff

  task automatic test_latch();
    xfer(1, OFS_STORE, 32'h00000008, 0, 0);
    pins(4'h0, 4'h0, 3'b100);
    check({31'h0, qa}, 32'h1);
    pins(4'h0, 4'h0, 3'b000);
    check({31'h0, qa}, 32'h0);
    k_req <= 1'b1;
    wait_cyc(12);
    pins(4'h0, 4'h0, 3'b100);
    check({31'h0, qa}, 32'h0);
    k_req <= 1'b0;
    wait_cyc(12);
    // latch with forced enable follows data even with the shared enable low
    xfer(1, OFS_STORE, 32'h00000018, 0, 0);
    ce <= 1'b0;
    pins(4'h0, 4'h0, 3'b000);
    check({31'h0, qa}, 32'h0);
    ce <= 1'b1;
    $display("test latch done");
  endtask : test_latch

  task automatic test_sr();
    xfer(1, OFS_STORE, 32'h0, 0, 0);
    pins(4'h0, 4'h0, 3'b000);
    kpulse();
    xfer(1, OFS_STORE, 32'h00004060, 0, 0);
    pins(4'h0, 4'h0, 3'b001);
    check({30'h0, qb, qa}, 32'h1);
    pins(4'h0, 4'h0, 3'b100);
    kpulse();
    check({30'h0, qb, qa}, 32'h3);
    pins(4'h0, 4'h0, 3'b000);
    kpulse();
    ce        <= 1'b0;
    global_sr <= 1'b1;
    wait_cyc(6);
    check({30'h0, qb, qa}, 32'h1);
    global_sr <= 1'b0;
    ce        <= 1'b1;
    wait_cyc(6);
    $display("test sr done");
  endtask : test_sr

  // element 0 stores f, element 1 stores h, both on the rising cell clock
  task automatic test_dsrc();
    xfer(1, OFS_STORE, 32'h00000201, 0, 0);
    pins(4'h2, 4'h0, 3'b010);
    kpulse();
    check({30'h0, qb, qa}, {30'h0, LH[2], LF[2]});
    $display("test dsrc done");
  endtask : test_dsrc

  // reset, then the scenarios one after another
  initial
  begin
    {rst_b_i, psel, penable, pwrite, hin0, hin1, hin2, ce, k_req, global_sr} = '0;
    {paddr, pwdata, f_in, g_in} = '0;
    en = 1'b1;
    repeat (8) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    wait_cyc(2);
    test_regs();
    test_lut();
    test_h();
    test_ff();
    test_latch();
    test_sr();
    test_dsrc();
    test_done();
  end
endmodule : logic_cell_bench
`default_nettype wire
